// *** pkg/ris_pkg.sv ***
// Package for the radio interrupt and sleep control block
package ris_pkg;

	// ----------------------------------------------------------------
	// Register map (byte addresses = 4 * index)
	// ----------------------------------------------------------------
	localparam logic [7:0]  IDX_CTRL       = 8'h04;
	localparam logic [7:0]  IDX_IRQ_ENABLE = 8'h0E;
	localparam logic [7:0]  IDX_IRQ_CAUSE  = 8'h0F;
	localparam logic [7:0]  IDX_STATE      = 8'h10;
	localparam logic [7:0]  IDX_MAN_ID_HI  = 8'h1F;
	localparam logic [7:0]  MAN_ID_HI_VAL  = 8'h5A; // Arbitrary value

	// ----------------------------------------------------------------
	// Control register fields and resets
	// ----------------------------------------------------------------
	localparam int          CTRL_POL_BIT    = 0;
	localparam int          CTRL_MMODE_BIT  = 1;
	localparam int          CTRL_CLKSEL_LSB = 2;
	localparam logic [7:0]  CTRL_RESET      = 8'h02;
	localparam logic [7:0]  ENABLE_RESET    = 8'h00;
	localparam logic [2:0]  CLKSEL_62K5     = 3'h6;
	localparam logic [2:0]  CLKSEL_RESET    = 3'h1;

	// ----------------------------------------------------------------
	// Cause bit positions
	// ----------------------------------------------------------------
	localparam int          CB_LOCK     = 0;
	localparam int          CB_UNLOCK   = 1;
	localparam int          CB_RXSTART  = 2;
	localparam int          CB_FRAME    = 3;
	localparam int          CB_MEAS     = 4;
	localparam int          CB_ADDR     = 5;
	localparam int          CB_BUF      = 6;
	localparam int          CB_LOWSUP   = 7;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam logic [5:0]  TRAIL_CYCLES  = 6'h23; // 35 output clock cycles
	localparam logic [3:0]  CLKDIV_HALF   = 4'h4;  // Output clock half period in CLK_I cycles

	// ----------------------------------------------------------------
	// Transceiver states and AXI response
	// ----------------------------------------------------------------
	typedef enum logic [4:0] {
		ST_OFF   = 5'h01,
		ST_SLEEP = 5'h02,
		ST_LOCK  = 5'h04,
		ST_ARET  = 5'h08,
		ST_TXBSY = 5'h10
	} ris_state_t;

	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic low_supply_event;
		logic buffer_violation_event;
		logic address_match_event;
		logic measurement_done_event;
		logic wake_complete_event;
		logic frame_rx_done_event;
		logic frame_done_event;
		logic rx_start_event;
		logic unlock_event;
		logic lock_event;
	} ris_evt_t;

endpackage : ris_pkg

// *** hw/ris_top.sv ***
// Interrupt unit, sleep/transmit trigger pin and clock output gating
// ------------------------------------------------------------------
// ------------------------------------------------------------------
`timescale 1ns/10ps
`default_nettype none

module ris_top (
	// Clock and reset
	input  wire logic               CLK_I,
	input  wire logic               RST_N_I,
	// AXI4-Lite write address and data
	input  wire logic               S_AWVALID_I,
	output logic                    S_AWREADY_O,
	input  wire logic [7:0]         S_AWADDR_I,
	input  wire logic               S_WVALID_I,
	output logic                    S_WREADY_O,
	input  wire logic [31:0]        S_WDATA_I,
	input  wire logic [3:0]         S_WSTRB_I,
	// AXI4-Lite write response
	output logic                    S_BVALID_O,
	input  wire logic               S_BREADY_I,
	output logic [1:0]              S_BRESP_O,
	// AXI4-Lite read
	input  wire logic               S_ARVALID_I,
	output logic                    S_ARREADY_O,
	input  wire logic [7:0]         S_ARADDR_I,
	output logic                    S_RVALID_O,
	input  wire logic               S_RREADY_I,
	output logic [31:0]             S_RDATA_O,
	output logic [1:0]              S_RRESP_O,
	// Events from the radio core
	input  wire ris_pkg::ris_evt_t  EVT_I,
	input  wire logic               TX_DONE_TO_LOCK_I,
	// Host pins
	input  wire logic               SLEEP_TX_TRIGGER_PIN_I,
	output logic                    IRQ_PIN_O,
	output logic                    CLOCK_OUTPUT_PIN_O,
	// Radio core control
	output logic                    TX_START_O,
	output logic                    ARET_START_O,
	output logic                    PA_ON_O,
	output logic [4:0]              STATE_O
);

	// ------------------------------------------------------------------
	// Trigger pin synchroniser
	// ------------------------------------------------------------------
	logic [2:0] trig_sync_q;
	logic       trig_lvl_q;
	wire logic  trig_agree = (trig_sync_q[1] == trig_sync_q[2]);
	wire logic  trig_rise  = trig_agree && trig_sync_q[2] && !trig_lvl_q;

	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			trig_sync_q <= 3'h0;
			trig_lvl_q  <= 1'b0;
		end else begin
			trig_sync_q <= {trig_sync_q[1:0], SLEEP_TX_TRIGGER_PIN_I};
			if (trig_agree)
				trig_lvl_q <= trig_sync_q[2];
		end
	end

	// ------------------------------------------------------------------
	// Register bus decode
	// ------------------------------------------------------------------
	logic [7:0] ctrl_q;
	logic [7:0] enable_q;
	logic [7:0] cause_q;
	logic [7:0] cause_d;
	logic       aw_held_q;
	logic       w_held_q;
	logic [7:0] aw_addr_q;
	logic [31:0] w_data_q;
	logic       w_lane0_q;

	function automatic logic [7:0] reg_idx(input logic [7:0] addr);
		return {2'h0, addr[7:2]};
	endfunction : reg_idx

	function automatic logic reg_known(input logic [7:0] idx);
		return idx == ris_pkg::IDX_CTRL || idx == ris_pkg::IDX_IRQ_ENABLE ||
		       idx == ris_pkg::IDX_IRQ_CAUSE || idx == ris_pkg::IDX_STATE ||
		       idx == ris_pkg::IDX_MAN_ID_HI;
	endfunction : reg_known

	wire logic       aw_take  = S_AWVALID_I && S_AWREADY_O;
	wire logic       w_take   = S_WVALID_I && S_WREADY_O;
	wire logic       wr_go    = aw_held_q && w_held_q && !S_BVALID_O;
	wire logic [7:0] wr_idx   = reg_idx(aw_addr_q);
	wire logic       wr_en    = wr_go && w_lane0_q;
	wire logic       ar_take  = S_ARVALID_I && S_ARREADY_O;
	wire logic [7:0] rd_idx   = reg_idx(S_ARADDR_I);
	wire logic       cause_rd = ar_take && rd_idx == ris_pkg::IDX_IRQ_CAUSE;

	ris_pkg::ris_state_t state_q;
	ris_pkg::ris_state_t state_d;

	logic [7:0] rd_val;
	always_comb begin
		case (rd_idx)
			ris_pkg::IDX_CTRL:       rd_val = ctrl_q;
			ris_pkg::IDX_IRQ_ENABLE: rd_val = enable_q;
			ris_pkg::IDX_IRQ_CAUSE:  rd_val = cause_q;
			ris_pkg::IDX_STATE:      rd_val = {3'h0, state_q};
			ris_pkg::IDX_MAN_ID_HI:  rd_val = ris_pkg::MAN_ID_HI_VAL;
			default:                 rd_val = 8'h00;
		endcase
	end

	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			aw_held_q   <= 1'b0;
			w_held_q    <= 1'b0;
			aw_addr_q   <= 8'h00;
			w_data_q    <= 32'h0000_0000;
			w_lane0_q   <= 1'b0;
			S_AWREADY_O <= 1'b0;
			S_WREADY_O  <= 1'b0;
			S_BVALID_O  <= 1'b0;
			S_BRESP_O   <= ris_pkg::RESP_OKAY;
			S_ARREADY_O <= 1'b0;
			S_RVALID_O  <= 1'b0;
			S_RDATA_O   <= 32'h0000_0000;
			S_RRESP_O   <= ris_pkg::RESP_OKAY;
		end else begin
			S_AWREADY_O <= !aw_held_q && !aw_take && !S_BVALID_O;
			S_WREADY_O  <= !w_held_q && !w_take && !S_BVALID_O;
			if (aw_take) begin
				aw_held_q <= 1'b1;
				aw_addr_q <= S_AWADDR_I;
			end
			if (w_take) begin
				w_held_q  <= 1'b1;
				w_data_q  <= S_WDATA_I;
				w_lane0_q <= S_WSTRB_I[0];
			end
			if (wr_go) begin
				S_BVALID_O <= 1'b1;
				S_BRESP_O  <= reg_known(wr_idx) ? ris_pkg::RESP_OKAY : ris_pkg::RESP_SLVERR;
				aw_held_q  <= 1'b0;
				w_held_q   <= 1'b0;
			end else if (S_BVALID_O && S_BREADY_I) begin
				S_BVALID_O <= 1'b0;
			end
			S_ARREADY_O <= !S_RVALID_O && !ar_take;
			if (ar_take) begin
				S_RVALID_O <= 1'b1;
				S_RDATA_O  <= {24'h00_0000, rd_val};
				S_RRESP_O  <= reg_known(rd_idx) ? ris_pkg::RESP_OKAY : ris_pkg::RESP_SLVERR;
			end else if (S_RVALID_O && S_RREADY_I) begin
				S_RVALID_O <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------------
	// Control and enable registers
	// ------------------------------------------------------------------
	logic [2:0] clksel_q;

	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			ctrl_q   <= ris_pkg::CTRL_RESET;
			enable_q <= ris_pkg::ENABLE_RESET;
			clksel_q <= ris_pkg::CLKSEL_RESET;
		end else if (wr_en) begin
			if (wr_idx == ris_pkg::IDX_CTRL) begin
				ctrl_q   <= w_data_q[7:0];
				clksel_q <= w_data_q[ris_pkg::CTRL_CLKSEL_LSB +: 3];
			end
			if (wr_idx == ris_pkg::IDX_IRQ_ENABLE)
				enable_q <= w_data_q[7:0];
		end
	end

	// ------------------------------------------------------------------
	// Transceiver state from trigger pin
	// ------------------------------------------------------------------
	always_comb begin
		state_d = state_q;
		case (state_q)
			ris_pkg::ST_OFF:   if (trig_rise) state_d = ris_pkg::ST_SLEEP;
			// Level sensitive wake: only a stable low leaves sleep
			ris_pkg::ST_SLEEP: if (trig_agree && !trig_sync_q[2]) state_d = ris_pkg::ST_OFF;
			ris_pkg::ST_LOCK:  if (trig_rise) state_d = ris_pkg::ST_TXBSY;
			ris_pkg::ST_ARET:  if (trig_rise) state_d = ris_pkg::ST_TXBSY;
			ris_pkg::ST_TXBSY: begin
				if (EVT_I.unlock_event || TX_DONE_TO_LOCK_I)
					state_d = ris_pkg::ST_LOCK;
			end
			default:           state_d = ris_pkg::ST_OFF;
		endcase
		if (state_q == ris_pkg::ST_OFF && EVT_I.lock_event)
			state_d = ris_pkg::ST_LOCK;
	end

	wire logic aret_sel = (ctrl_q[7] == 1'b1);
	wire logic wake_end = (state_q == ris_pkg::ST_SLEEP) && (state_d == ris_pkg::ST_OFF);

	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			state_q      <= ris_pkg::ST_OFF;
			TX_START_O   <= 1'b0;
			ARET_START_O <= 1'b0;
			PA_ON_O      <= 1'b0;
		end else begin
			state_q      <= (state_d == ris_pkg::ST_LOCK && aret_sel) ? ris_pkg::ST_ARET : state_d;
			// Only edges start transmissions; a held level does nothing
			TX_START_O   <= trig_rise && state_q == ris_pkg::ST_LOCK;
			ARET_START_O <= trig_rise && state_q == ris_pkg::ST_ARET;
			PA_ON_O      <= state_d == ris_pkg::ST_TXBSY && !EVT_I.unlock_event;
		end
	end

	// ------------------------------------------------------------------
	// Clock output divider and sleep gating
	// ------------------------------------------------------------------
	logic [3:0] div_q;
	logic [5:0] trail_q;
	logic       clk_run_q;
	wire logic  half_done = (div_q == ris_pkg::CLKDIV_HALF - 4'h1);
	wire logic  fall_edge = half_done && CLOCK_OUTPUT_PIN_O;
	wire logic  sleep_entry = state_q == ris_pkg::ST_OFF && state_d == ris_pkg::ST_SLEEP;

	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			div_q              <= 4'h0;
			trail_q            <= 6'h00;
			clk_run_q          <= 1'b1;
			CLOCK_OUTPUT_PIN_O <= 1'b0;
		end else begin
			div_q <= half_done ? 4'h0 : div_q + 4'h1;
			if (half_done && (clk_run_q || CLOCK_OUTPUT_PIN_O))
				CLOCK_OUTPUT_PIN_O <= clk_run_q ? !CLOCK_OUTPUT_PIN_O : 1'b0;
			if (sleep_entry) begin
				trail_q   <= ris_pkg::TRAIL_CYCLES;
				clk_run_q <= clksel_q != ris_pkg::CLKSEL_62K5;
				if (clksel_q == ris_pkg::CLKSEL_62K5)
					CLOCK_OUTPUT_PIN_O <= 1'b0;
			end else if (state_q == ris_pkg::ST_OFF) begin
				clk_run_q <= 1'b1;
			end else if (state_q == ris_pkg::ST_SLEEP && clk_run_q && fall_edge) begin
				trail_q <= trail_q - 6'h01;
				if (trail_q == 6'h01)
					clk_run_q <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------------
	// Interrupt causes
	// ------------------------------------------------------------------
	wire logic [7:0] evt_vec;
	assign evt_vec[ris_pkg::CB_LOWSUP]  = EVT_I.low_supply_event;
	assign evt_vec[ris_pkg::CB_BUF]     = EVT_I.buffer_violation_event;
	assign evt_vec[ris_pkg::CB_ADDR]    = EVT_I.address_match_event;
	assign evt_vec[ris_pkg::CB_MEAS]    = EVT_I.measurement_done_event ||
	                                      EVT_I.wake_complete_event || wake_end;
	assign evt_vec[ris_pkg::CB_FRAME]   = EVT_I.frame_done_event ||
	                                      EVT_I.frame_rx_done_event;
	assign evt_vec[ris_pkg::CB_RXSTART] = EVT_I.rx_start_event;
	assign evt_vec[ris_pkg::CB_UNLOCK]  = EVT_I.unlock_event;
	assign evt_vec[ris_pkg::CB_LOCK]    = EVT_I.lock_event;

	wire logic       mask_mode = ctrl_q[ris_pkg::CTRL_MMODE_BIT];
	wire logic [7:0] recorded  = mask_mode ? evt_vec : (evt_vec & enable_q);

	always_comb begin
		// Clearing read first, then new events win over it
		cause_d = cause_rd ? 8'h00 : cause_q;
		cause_d = cause_d | recorded;
		// Lock and unlock are mutually exclusive, except that both stay set when they arrive in the same cycle
		if (recorded[ris_pkg::CB_LOCK] && !recorded[ris_pkg::CB_UNLOCK])
			cause_d[ris_pkg::CB_UNLOCK] = 1'b0;
		if (recorded[ris_pkg::CB_UNLOCK] && !recorded[ris_pkg::CB_LOCK])
			cause_d[ris_pkg::CB_LOCK] = 1'b0;
	end

	wire logic irq_act = |(cause_d & enable_q);

	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			cause_q   <= 8'h00;
			IRQ_PIN_O <= 1'b0;
		end else begin
			cause_q   <= cause_d;
			IRQ_PIN_O <= irq_act ^ ctrl_q[ris_pkg::CTRL_POL_BIT];
		end
	end

	assign STATE_O = state_q;

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	property p_rd_clear;
		@(posedge CLK_I) disable iff (!RST_N_I)
		cause_rd && recorded == 8'h00 |=> cause_q == 8'h00;
	endproperty
	a_rd_clear: assert property (p_rd_clear) else $error("cause not cleared");

	property p_keep_evt;
		@(posedge CLK_I) disable iff (!RST_N_I)
		cause_rd |=> (cause_q & $past(recorded)) == $past(recorded);
	endproperty
	a_keep_evt: assert property (p_keep_evt) else $error("event lost on read");

	property p_irq_or;
		@(posedge CLK_I) disable iff (!RST_N_I)
		##1 (IRQ_PIN_O ^ $past(ctrl_q[ris_pkg::CTRL_POL_BIT])) ==
		|($past(cause_d) & $past(enable_q));
	endproperty
	a_irq_or: assert property (p_irq_or) else $error("irq pin mismatch");

	property p_sleep_entry;
		@(posedge CLK_I) disable iff (!RST_N_I)
		state_q == ris_pkg::ST_OFF && trig_rise |=> state_q == ris_pkg::ST_SLEEP;
	endproperty
	a_sleep_entry: assert property (p_sleep_entry) else $error("no sleep entry");

	property p_sleep_hold;
		@(posedge CLK_I) disable iff (!RST_N_I)
		state_q == ris_pkg::ST_SLEEP && trig_lvl_q && trig_sync_q[2] |=>
		state_q == ris_pkg::ST_SLEEP;
	endproperty
	a_sleep_hold: assert property (p_sleep_hold) else $error("left sleep while high");

	property p_tx_start;
		@(posedge CLK_I) disable iff (!RST_N_I)
		state_q == ris_pkg::ST_LOCK && trig_rise |=> TX_START_O ##1 !TX_START_O;
	endproperty
	a_tx_start: assert property (p_tx_start) else $error("tx start missing");

	property p_edge_only;
		@(posedge CLK_I) disable iff (!RST_N_I)
		!trig_rise |=> !TX_START_O && !ARET_START_O;
	endproperty
	a_edge_only: assert property (p_edge_only) else $error("start without edge");

	property p_lock_excl;
		@(posedge CLK_I) disable iff (!RST_N_I)
		recorded[ris_pkg::CB_LOCK] && !recorded[ris_pkg::CB_UNLOCK] |=>
		!cause_q[ris_pkg::CB_UNLOCK] && cause_q[ris_pkg::CB_LOCK];
	endproperty
	a_lock_excl: assert property (p_lock_excl) else $error("lock did not clear unlock");

	property p_slow_stop;
		@(posedge CLK_I) disable iff (!RST_N_I)
		sleep_entry && clksel_q == ris_pkg::CLKSEL_62K5 |=> !CLOCK_OUTPUT_PIN_O [*8];
	endproperty
	a_slow_stop: assert property (p_slow_stop) else $error("slow clock kept running");

	property p_pa_cut;
		@(posedge CLK_I) disable iff (!RST_N_I)
		EVT_I.unlock_event |=> !PA_ON_O;
	endproperty
	a_pa_cut: assert property (p_pa_cut) else $error("amplifier not cut");

	c_sleep_wake: cover property (@(posedge CLK_I) disable iff (!RST_N_I)
		state_q == ris_pkg::ST_SLEEP ##1 state_q == ris_pkg::ST_OFF);
	c_irq_read: cover property (@(posedge CLK_I) disable iff (!RST_N_I)
		IRQ_PIN_O && cause_rd);
	c_aret: cover property (@(posedge CLK_I) disable iff (!RST_N_I) ARET_START_O);

endmodule : ris_top

`default_nettype wire

// *** verif/ris_host_model.sv ***
// Host microcontroller model: drives the trigger pin, watches the interrupt pin
`timescale 1ns/10ps
`default_nettype none

module ris_host_model (
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic rst_n_i,
	// Bench requests
	input  wire logic pin_req_i,
	input  wire logic irq_pol_i,
	// Device pins
	input  wire logic irq_pin_i,
	output logic      trigger_pin_o,
	output logic      irq_seen_o
);
	// Push-pull pin, so it never floats between uses
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			trigger_pin_o <= 1'b0;
			irq_seen_o    <= 1'b0;
		end else begin
			trigger_pin_o <= pin_req_i;
			if (irq_pin_i ^ irq_pol_i)
				irq_seen_o <= 1'b1;
		end
	end
endmodule : ris_host_model
`default_nettype wire

// *** verif/radio_irq_and_sleep_control_bench.sv ***
// Self-checking bench for the interrupt unit and trigger pin block
`timescale 1ns/10ps
`default_nettype none

module radio_irq_and_sleep_control_bench;
	localparam logic [7:0] A_CTRL  = ris_pkg::IDX_CTRL << 2;
	localparam logic [7:0] A_EN    = ris_pkg::IDX_IRQ_ENABLE << 2;
	localparam logic [7:0] A_CAUSE = ris_pkg::IDX_IRQ_CAUSE << 2;
	localparam logic [7:0] A_STATE = ris_pkg::IDX_STATE << 2;
	localparam logic [7:0] A_ID    = ris_pkg::IDX_MAN_ID_HI << 2;
	logic               clk, rst_n, awv, wv, bready, arv, rready, tx_done, pin_req, pol;
	logic               awready, wready, bvalid, arready, rvalid, irq, clkout, clk_prev;
	logic               tx_start, aret_start, pa_on, trig, irq_seen;
	logic [7:0]         awa, ara;
	logic [31:0]        wd, rdata;
	logic [1:0]         bresp, rresp;
	logic [4:0]         state, st_prev;
	ris_pkg::ris_evt_t  evt;
	int                 n_mismatch = 0, n_compared = 0, cyc = 0, n_fall = 0, n_tx = 0, n_aret = 0;
	int                 cmap [10] = '{0, 1, 2, 3, 3, 4, 4, 5, 6, 7};

	ris_top dut (
		.CLK_I(clk), .RST_N_I(rst_n),
		.S_AWVALID_I(awv), .S_AWREADY_O(awready), .S_AWADDR_I(awa),
		.S_WVALID_I(wv), .S_WREADY_O(wready), .S_WDATA_I(wd), .S_WSTRB_I(4'hF),
		.S_BVALID_O(bvalid), .S_BREADY_I(bready), .S_BRESP_O(bresp),
		.S_ARVALID_I(arv), .S_ARREADY_O(arready), .S_ARADDR_I(ara),
		.S_RVALID_O(rvalid), .S_RREADY_I(rready), .S_RDATA_O(rdata), .S_RRESP_O(rresp),
		.EVT_I(evt), .TX_DONE_TO_LOCK_I(tx_done), .SLEEP_TX_TRIGGER_PIN_I(trig),
		.IRQ_PIN_O(irq), .CLOCK_OUTPUT_PIN_O(clkout), .TX_START_O(tx_start),
		.ARET_START_O(aret_start), .PA_ON_O(pa_on), .STATE_O(state)
	);

	ris_host_model host (
		.clk_i(clk), .rst_n_i(rst_n), .pin_req_i(pin_req), .irq_pol_i(pol),
		.irq_pin_i(irq), .trigger_pin_o(trig), .irq_seen_o(irq_seen)
	);

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// Falling edges of the clock output while asleep, start pulses, hang guard
	always @(posedge clk) begin
		clk_prev <= clkout;
		st_prev  <= state;
		// A fall launched on the entry edge itself belongs to the off state
		if (state !== ris_pkg::ST_SLEEP)
			n_fall <= 0;
		else if (st_prev === ris_pkg::ST_SLEEP && clk_prev === 1'b1 && clkout === 1'b0)
			n_fall <= n_fall + 1;
		if (tx_start === 1'b1)
			n_tx <= n_tx + 1;
		if (aret_start === 1'b1)
			n_aret <= n_aret + 1;
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_mismatch = n_mismatch + 1;
			conclude();
		end
	end

	// ------------------------------------------------
	// Tasks
	// ------------------------------------------------
	task conclude;
		$display("mismatches %0d compared %0d", n_mismatch, n_compared);
		if (n_mismatch == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : conclude

	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	function automatic ris_pkg::ris_evt_t ev(input int k);
		return ris_pkg::ris_evt_t'(10'h001 << k);
	endfunction : ev

	task do_reset;
		rst_n <= 1'b0;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
	endtask : do_reset

	// Response ready stays high throughout, which the bus allows
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
			input logic [1:0] er = ris_pkg::RESP_OKAY);
		logic aw, w, b;
		aw = 1'b0;
		w = 1'b0;
		b = 1'b0;
		awv <= 1'b1;
		wv <= 1'b1;
		awa <= a;
		wd <= d;
		while (!b) begin
			@(posedge clk);
			if (!aw && awready) begin
				aw = 1'b1;
				awv <= 1'b0;
			end
			if (!w && wready) begin
				w = 1'b1;
				wv <= 1'b0;
			end
			if (bvalid) begin
				b = 1'b1;
				chk(bresp, er);
			end
		end
	endtask : wr

	// An event handed in stands one edge only: call with the bus idle so that edge takes it
	task automatic rd(input logic [7:0] a, input logic [31:0] ed,
			input logic [1:0] er = ris_pkg::RESP_OKAY, input ris_pkg::ris_evt_t e = '0);
		logic ar, r;
		ar = 1'b0;
		r = 1'b0;
		arv <= 1'b1;
		ara <= a;
		evt <= e;
		while (!r) begin
			@(posedge clk);
			evt <= '0;
			if (!ar && arready) begin
				ar = 1'b1;
				arv <= 1'b0;
			end else if (ar && rvalid) begin
				r = 1'b1;
				chk(rdata, ed);
				chk(rresp, er);
			end
		end
	endtask : rd

	task pulse(input ris_pkg::ris_evt_t e);
		evt <= e;
		@(posedge clk);
		evt <= '0;
		@(posedge clk);
	endtask : pulse

	task ws(input logic [4:0] s);
		for (int i = 0; i < 50 && state !== s; i++)
			@(posedge clk);
		repeat (2) @(posedge clk);
		chk(state, s);
	endtask : ws

	// ------------------------------------------------
	// Sequence
	// ------------------------------------------------
	initial begin
		{awv, wv, arv, tx_done, pin_req, pol} = '0;
		{awa, ara, wd} = '0;
		{bready, rready} = 2'b11;
		evt = '0;
		do_reset();
		rd(A_EN, 32'h0);
		rd(A_CTRL, {24'h0, ris_pkg::CTRL_RESET});
		rd(A_ID, {24'h0, ris_pkg::MAN_ID_HI_VAL});
		rd(A_STATE, 32'h1);
		rd(A_CAUSE, 32'h0);
		chk(irq, 1'b0);
		rd(8'h80, 32'h0, ris_pkg::RESP_SLVERR);
		wr(8'h80, 32'hFF, ris_pkg::RESP_SLVERR);
		wr(A_ID, 32'hFF);
		rd(A_ID, {24'h0, ris_pkg::MAN_ID_HI_VAL});
		wr(A_CTRL, 32'h03);
		pol <= 1'b1;
		repeat (3) @(posedge clk);
		chk(irq, 1'b1);
		wr(A_CTRL, 32'h00);
		pol <= 1'b0;
		pulse(ev(7));
		rd(A_CAUSE, 32'h0);
		wr(A_EN, 32'h20);
		pulse(ev(7));
		repeat (2) @(posedge clk);
		chk(irq, 1'b1);
		rd(A_CAUSE, 32'h20);
		repeat (2) @(posedge clk);
		chk(irq, 1'b0);
		wr(A_EN, 32'h0);
		wr(A_CTRL, 32'h02);
		pulse(ev(8));
		repeat (2) @(posedge clk);
		chk(irq, 1'b0);
		rd(A_CAUSE, 32'h40);
		repeat (3) @(posedge clk);
		rd(A_CAUSE, 32'h0, ris_pkg::RESP_OKAY, ev(3));
		rd(A_CAUSE, 32'h08);
		pin_req <= 1'b1;
		ws(ris_pkg::ST_SLEEP);
		repeat (400) @(posedge clk);
		chk(n_fall, 35);
		chk(clkout, 1'b0);
		chk(state, ris_pkg::ST_SLEEP);
		pin_req <= 1'b0;
		ws(ris_pkg::ST_OFF);
		rd(A_CAUSE, 32'h10);
		wr(A_CTRL, 32'h1A);
		pin_req <= 1'b1;
		ws(ris_pkg::ST_SLEEP);
		repeat (40) @(posedge clk);
		chk(n_fall, 0);
		chk(clkout, 1'b0);
		pin_req <= 1'b0;
		ws(ris_pkg::ST_OFF);
		wr(A_CTRL, 32'h02);
		rd(A_CAUSE, 32'h10);
		wr(A_EN, 32'hFF);
		for (int i = 0; i < 10; i++) begin
			pulse(ev(i));
			repeat (2) @(posedge clk);
			chk(irq, 1'b1);
			rd(A_CAUSE, 32'h1 << cmap[i]);
			repeat (2) @(posedge clk);
			chk(irq, 1'b0);
		end
		chk(irq_seen, 1'b1);
		pulse(ev(0));
		pin_req <= 1'b1;
		ws(ris_pkg::ST_TXBSY);
		chk(n_tx, 1);
		chk(pa_on, 1'b1);
		pulse(ev(1));
		repeat (2) @(posedge clk);
		chk(pa_on, 1'b0);
		ws(ris_pkg::ST_LOCK);
		rd(A_CAUSE, 32'h02);
		pulse(ev(1));
		pulse(ev(0));
		rd(A_CAUSE, 32'h01);
		pin_req <= 1'b0;
		repeat (10) @(posedge clk);
		chk(state, ris_pkg::ST_LOCK);
		chk(n_tx, 1);
		pin_req <= 1'b1;
		ws(ris_pkg::ST_TXBSY);
		chk(n_tx, 2);
		tx_done <= 1'b1;
		@(posedge clk);
		tx_done <= 1'b0;
		ws(ris_pkg::ST_LOCK);
		pin_req <= 1'b0;
		repeat (5) @(posedge clk);
		do_reset();
		rd(A_EN, 32'h0);
		wr(A_CTRL, 32'h82);
		pulse(ev(0));
		ws(ris_pkg::ST_ARET);
		pin_req <= 1'b1;
		ws(ris_pkg::ST_TXBSY);
		chk(n_aret, 1);
		pin_req <= 1'b0;
		conclude();
	end
endmodule : radio_irq_and_sleep_control_bench
`default_nettype wire
